/* File: hw/hub_pkg.sv */
package hub_pkg;

  // Serial-port register addresses on the device
  localparam logic [7:0] EVENT_FLAG_ADDR    = 8'hE8;
  localparam logic [7:0] EVENT_MASK_ADDR    = 8'hE9;
  localparam logic [7:0] PORTABLE_CFG_ADDR  = 8'hEE;

  // Field positions in portable_config_register
  localparam int SUSPEND_LEVEL_SELECT_BIT   = 0;
  localparam int CONNECT_GO_BIT             = 1;

  // Device register values after reset
  localparam logic [7:0] EVENT_FLAG_RESET   = 8'h00;
  localparam logic [7:0] EVENT_MASK_RESET   = 8'h00;
  localparam logic [7:0] PORTABLE_CFG_RESET = 8'h00;

  // Controller APB register offsets
  localparam logic [7:0] CMD_OFF            = 8'h00;
  localparam logic [7:0] SER_OFF            = 8'h04;
  localparam logic [7:0] STAT_OFF           = 8'h08;

  // Field positions in the controller registers
  localparam int SER_WDATA_LSB              = 0;
  localparam int SER_ADDR_LSB               = 8;
  localparam int SER_WE_BIT                 = 16;
  localparam int STAT_BUSY_BIT              = 0;
  localparam int STAT_ALERT_BIT             = 1;
  localparam int STAT_MODE_LSB              = 2;
  localparam int STAT_RDATA_LSB             = 8;

  // Timing
  localparam int CLK_MHZ                    = 100;
  localparam int RESET_HOLD_US              = 100;
  localparam int RESET_HOLD_CYCLES          = RESET_HOLD_US * CLK_MHZ;
  localparam int INIT_CYCLES                = 16;

  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_BYPASS,
    MODE_HUB
  } op_mode_e;

  typedef enum logic [1:0] {
    STAGE_OFF,
    STAGE_INIT,
    STAGE_CONFIG,
    STAGE_COM
  } hub_stage_e;

endpackage

/* File: hw/hub_link_if.sv */
`timescale 1ns/1ps
interface hub_link_if;
  logic       reset_n;
  logic       bypass_n;
  logic       alert_oe;
  wire        alert_n;
  logic       reg_req;
  logic       reg_we;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_ack;

  // Open-drain alert line with external pull-up
  assign alert_n = alert_oe ? 1'b0 : 1'b1;

  modport dev (
    input  reset_n,
    input  bypass_n,
    output alert_oe,
    input  reg_req,
    input  reg_we,
    input  reg_addr,
    input  reg_wdata,
    output reg_rdata,
    output reg_ack
  );

  modport host (
    output reset_n,
    output bypass_n,
    input  alert_n,
    output reg_req,
    output reg_we,
    output reg_addr,
    output reg_wdata,
    input  reg_rdata,
    input  reg_ack
  );
endinterface

/* File: hw/hub_ctrl_dev.sv */
// Chosen here: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Event conditions recorded in flag register E8h
// - Mask register E9h gates flags onto alert
// - Flags stay set until serial clear
// - Flags set again only on fresh rise
// - Suspend-level option makes alert a level
// - Level alert ignores per-port selective suspend
// - Level alert high configured awake, else low
// - Level alert follows state without serial access
// - Alert active low, open drain
// - Mode decoded from reset and bypass inputs
// - Standby only watches pins, regulators off
// - Standby keeps no configuration
// - Reset held low at least 100 us
// - Reset disables ports, clears registers, halts PLL
// - Load ROM settings in init stage
// - Bypass connects port 3 through switch
// - Bypass entered after reset pulse
// - Bypass turns off 1.2V, PLL, core
// - Hub mode opens switch, full hub
// - Communication stage held until mode changes
module hub_ctrl_dev #(
  parameter int unsigned INIT_CYCLES = hub_pkg::INIT_CYCLES
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  hub_link_if.dev            link,
  input  wire logic [7:0]    event_cond,
  input  wire logic          usb_configured,
  input  wire logic          usb_suspended,
  output hub_pkg::op_mode_e  op_mode,
  output hub_pkg::hub_stage_e stage,
  output logic               switch_on,
  output logic               reg12_on,
  output logic               reg33_on,
  output logic               pll_run,
  output logic               ports_en,
  output logic               rom_load
);

  logic [2:0]          rst_sync_q;
  logic [2:0]          byp_sync_q;
  logic                rst_pin_q;
  logic                byp_pin_q;
  hub_pkg::op_mode_e   mode_q;
  hub_pkg::hub_stage_e stage_q;
  logic [15:0]         init_cnt_q;
  logic                core_off;
  logic [7:0]          flag_q;
  logic [7:0]          flag_d;
  logic [7:0]          mask_q;
  logic [7:0]          cfg_q;
  logic [7:0]          cond_prev_q;
  logic                ack_q;
  logic [7:0]          rdata_q;
  logic                alert_oe_q;
  logic                rom_load_q;
  logic                acc;
  logic                wr_ok;

  assign core_off = (mode_q != hub_pkg::MODE_HUB);
  assign acc      = link.reg_req & ~ack_q;
  // Serial port only usable in the configuration stage
  assign wr_ok    = acc & link.reg_we & (stage_q == hub_pkg::STAGE_CONFIG);

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_sync_q <= 3'h0;
      byp_sync_q <= 3'h0;
      rst_pin_q  <= 1'b0;
      byp_pin_q  <= 1'b0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[1:0], link.reset_n};
      byp_sync_q <= {byp_sync_q[1:0], link.bypass_n};
      if (rst_sync_q[1] == rst_sync_q[2])
        rst_pin_q <= rst_sync_q[2];
      if (byp_sync_q[1] == byp_sync_q[2])
        byp_pin_q <= byp_sync_q[2];
    end
  end

  // Mode decode; reset low always means standby
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= hub_pkg::MODE_STANDBY;
    else if (!rst_pin_q)
      mode_q <= hub_pkg::MODE_STANDBY;
    else if (!byp_pin_q)
      mode_q <= hub_pkg::MODE_BYPASS;
    else
      mode_q <= hub_pkg::MODE_HUB;
  end

  // Power, switch and clock controls follow the mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      switch_on <= 1'b0;
      reg12_on  <= 1'b0;
      reg33_on  <= 1'b0;
      pll_run   <= 1'b0;
      ports_en  <= 1'b0;
    end
    else
    begin
      switch_on <= (mode_q == hub_pkg::MODE_BYPASS);
      reg12_on  <= (mode_q == hub_pkg::MODE_HUB);
      reg33_on  <= (mode_q != hub_pkg::MODE_STANDBY);
      pll_run   <= (mode_q == hub_pkg::MODE_HUB);
      ports_en  <= (stage_q == hub_pkg::STAGE_COM);
    end
  end

  // Hub stages; core off in standby and bypass resets them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_q    <= hub_pkg::STAGE_OFF;
      init_cnt_q <= 16'h0000;
      rom_load_q <= 1'b0;
    end
    else
    begin
      rom_load_q <= 1'b0;
      if (core_off)
      begin
        stage_q    <= hub_pkg::STAGE_OFF;
        init_cnt_q <= 16'h0000;
      end
      else
      begin
        unique case (stage_q)
          hub_pkg::STAGE_OFF:
          begin
            stage_q    <= hub_pkg::STAGE_INIT;
            rom_load_q <= 1'b1;
          end
          hub_pkg::STAGE_INIT:
          begin
            if (init_cnt_q == 16'(INIT_CYCLES - 1))
              stage_q <= hub_pkg::STAGE_CONFIG;
            else
              init_cnt_q <= init_cnt_q + 16'h0001;
          end
          hub_pkg::STAGE_CONFIG:
          begin
            if (cfg_q[hub_pkg::CONNECT_GO_BIT])
              stage_q <= hub_pkg::STAGE_COM;
          end
          hub_pkg::STAGE_COM:
            stage_q <= hub_pkg::STAGE_COM;
        endcase
      end
    end
  end

  // Flags: set on a rising condition, cleared by writing one; set wins
  always_comb
  begin
    flag_d = flag_q & ~((wr_ok && link.reg_addr == hub_pkg::EVENT_FLAG_ADDR)
                        ? link.reg_wdata : 8'h00);
    flag_d = flag_d | (event_cond & ~cond_prev_q);
  end

  // Device registers, all back to defaults whenever the core is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_q      <= hub_pkg::EVENT_FLAG_RESET;
      mask_q      <= hub_pkg::EVENT_MASK_RESET;
      cfg_q       <= hub_pkg::PORTABLE_CFG_RESET;
      cond_prev_q <= 8'h00;
    end
    else if (core_off)
    begin
      flag_q      <= hub_pkg::EVENT_FLAG_RESET;
      mask_q      <= hub_pkg::EVENT_MASK_RESET;
      cfg_q       <= hub_pkg::PORTABLE_CFG_RESET;
      cond_prev_q <= 8'h00;
    end
    else
    begin
      cond_prev_q <= event_cond;
      flag_q      <= flag_d;
      if (wr_ok && link.reg_addr == hub_pkg::EVENT_MASK_ADDR)
        mask_q <= link.reg_wdata;
      if (wr_ok && link.reg_addr == hub_pkg::PORTABLE_CFG_ADDR)
        cfg_q <= link.reg_wdata;
    end
  end

  // Serial port answer: ack one cycle after request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      ack_q <= acc;
      if (acc)
      begin
        if (stage_q != hub_pkg::STAGE_CONFIG || link.reg_we)
          rdata_q <= 8'h00;
        else if (link.reg_addr == hub_pkg::EVENT_FLAG_ADDR)
          rdata_q <= flag_q;
        else if (link.reg_addr == hub_pkg::EVENT_MASK_ADDR)
          rdata_q <= mask_q;
        else if (link.reg_addr == hub_pkg::PORTABLE_CFG_ADDR)
          rdata_q <= cfg_q;
        else
          rdata_q <= 8'h00;
      end
    end
  end

  // Alert pin: pull low when active, else release to pull-up
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alert_oe_q <= 1'b0;
    else if (core_off)
      alert_oe_q <= 1'b0;
    else if (cfg_q[hub_pkg::SUSPEND_LEVEL_SELECT_BIT])
      alert_oe_q <= ~(usb_configured & ~usb_suspended);
    else
      alert_oe_q <= |(flag_q & mask_q);
  end

  assign link.alert_oe  = alert_oe_q;
  assign link.reg_ack   = ack_q;
  assign link.reg_rdata = rdata_q;
  assign op_mode        = mode_q;
  assign stage          = stage_q;
  assign rom_load       = rom_load_q;

endmodule

/* File: hw/hub_ctrl_host.sv */
`timescale 1ns/1ps
module hub_ctrl_host #(
  parameter int unsigned RESET_HOLD_CYCLES = hub_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  hub_link_if.host         link
);

  typedef enum logic [2:0] {
    S_STBY,
    S_HOLD,
    S_REL,
    S_BYP,
    S_HUB
  } seq_e;

  seq_e              seq_q;
  logic [15:0]       hold_cnt_q;
  logic [1:0]        target_q;
  logic              rst_n_q;
  logic              byp_n_q;
  logic              req_q;
  logic              we_q;
  logic [7:0]        addr_q;
  logic [7:0]        wdata_q;
  logic [7:0]        rdata_q;
  logic [2:0]        al_sync_q;
  logic              al_q;
  logic [31:0]       prdata_q;
  logic              wr;
  logic              cmd_wr;
  logic              ser_wr;
  logic              mapped;
  logic [31:0]       stat;

  assign wr     = psel & penable & pwrite;
  assign cmd_wr = wr & (paddr == hub_pkg::CMD_OFF);
  assign ser_wr = wr & (paddr == hub_pkg::SER_OFF) & ~req_q;
  assign mapped = (paddr == hub_pkg::CMD_OFF) | (paddr == hub_pkg::SER_OFF)
                | (paddr == hub_pkg::STAT_OFF);

  // Status word built from controller state
  always_comb
  begin
    stat = 32'h0000_0000;
    stat[hub_pkg::STAT_BUSY_BIT]  = req_q;
    stat[hub_pkg::STAT_ALERT_BIT] = ~al_q;
    stat[hub_pkg::STAT_MODE_LSB +: 2] = {~byp_n_q & rst_n_q, rst_n_q & byp_n_q};
    stat[hub_pkg::STAT_RDATA_LSB +: 8] = rdata_q;
  end

  // APB: zero wait states, read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == hub_pkg::CMD_OFF)
        prdata_q <= {30'h0000_0000, target_q};
      else if (paddr == hub_pkg::STAT_OFF)
        prdata_q <= stat;
      else if (paddr == hub_pkg::SER_OFF)
        prdata_q <= {15'h0000, we_q, addr_q, wdata_q};
      else
        prdata_q <= 32'h0000_0000;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Mode sequencer: every change passes a timed reset pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_q      <= S_STBY;
      target_q   <= 2'h0;
      hold_cnt_q <= 16'h0000;
      rst_n_q    <= 1'b0;
      byp_n_q    <= 1'b0;
    end
    else if (cmd_wr)
    begin
      target_q   <= pwdata[1:0];
      seq_q      <= S_HOLD;
      hold_cnt_q <= 16'h0000;
      rst_n_q    <= 1'b0;
      byp_n_q    <= 1'b1;
    end
    else
    begin
      unique case (seq_q)
        S_STBY:
        begin
          rst_n_q <= 1'b0;
          byp_n_q <= 1'b0;
        end
        S_HOLD:
        begin
          if (hold_cnt_q == 16'(RESET_HOLD_CYCLES - 1))
          begin
            if (target_q == 2'(hub_pkg::MODE_HUB))
            begin
              seq_q   <= S_HUB;
              rst_n_q <= 1'b1;
            end
            else if (target_q == 2'(hub_pkg::MODE_BYPASS))
            begin
              seq_q   <= S_REL;
              rst_n_q <= 1'b1;
            end
            else
            begin
              seq_q   <= S_STBY;
              byp_n_q <= 1'b0;
            end
          end
          else
            hold_cnt_q <= hold_cnt_q + 16'h0001;
        end
        S_REL:
        begin
          seq_q   <= S_BYP;
          byp_n_q <= 1'b0;
        end
        S_BYP:
          seq_q <= S_BYP;
        S_HUB:
          seq_q <= S_HUB;
        default:
          seq_q <= S_STBY;
      endcase
    end
  end

  // Serial request toward the device; held until the device acknowledges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= 8'h00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
    end
    else if (ser_wr)
    begin
      req_q   <= 1'b1;
      we_q    <= pwdata[hub_pkg::SER_WE_BIT];
      addr_q  <= pwdata[hub_pkg::SER_ADDR_LSB +: 8];
      wdata_q <= pwdata[hub_pkg::SER_WDATA_LSB +: 8];
    end
    else if (req_q && link.reg_ack)
    begin
      req_q   <= 1'b0;
      rdata_q <= link.reg_rdata;
    end
  end

  // Alert pin synchroniser; change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      al_sync_q <= 3'h7;
      al_q      <= 1'b1;
    end
    else
    begin
      al_sync_q <= {al_sync_q[1:0], link.alert_n};
      if (al_sync_q[1] == al_sync_q[2])
        al_q <= al_sync_q[2];
    end
  end

  assign link.reset_n   = rst_n_q;
  assign link.bypass_n  = byp_n_q;
  assign link.reg_req   = req_q;
  assign link.reg_we    = we_q;
  assign link.reg_addr  = addr_q;
  assign link.reg_wdata = wdata_q;

endmodule

/* File: verification/hub_mode_and_alert_control_checker.sv */
`timescale 1ns/1ps
module hub_mode_and_alert_control_checker #(
  parameter int unsigned HOLD_CYCLES = hub_pkg::RESET_HOLD_CYCLES
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       reset_n,
  input wire logic       bypass_n,
  input wire logic       alert_oe,
  input wire logic       alert_n,
  input wire logic       reg_req,
  input wire logic       reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_ack
);
  logic [15:0] low_cnt_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Counts how long the mode reset line has been held low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt_q <= '0;
    else if (reset_n)
      low_cnt_q <= '0;
    else if (low_cnt_q != 16'hFFFF)
      low_cnt_q <= low_cnt_q + 16'h0001;
  end

  chk_open_drain: assert property (alert_n == !alert_oe)
    else $error("alert line does not follow its pull-down enable");
  chk_ack_pulse: assert property (reg_ack |=> !reg_ack && !reg_req)
    else $error("serial acknowledge not a single pulse");
  chk_ack_timely: assert property ($rose(reg_req) |=> reg_ack)
    else $error("serial acknowledge late");
  chk_ack_cause: assert property (reg_ack |-> $past(reg_req))
    else $error("serial acknowledge without request");
  chk_req_hold: assert property (reg_req && !reg_ack |=>
    reg_req && $stable({reg_we, reg_addr, reg_wdata}))
    else $error("serial request changed before acknowledge");
  chk_reset_hold: assert property ($rose(reset_n) |->
    low_cnt_q >= HOLD_CYCLES)
    else $error("mode reset released too early");
  chk_bypass_order: assert property ($fell(bypass_n) && reset_n |->
    !$past(reset_n, 2))
    else $error("bypass entered without reset pulse");
  chk_standby_quiet: assert property ((!reset_n) [*8] |-> !alert_oe)
    else $error("alert driven while held in standby");

  // Main scenarios reached
  cover property ($rose(reg_ack));
  cover property ($fell(bypass_n) && reset_n);
  cover property (alert_oe ##1 !alert_oe);
endmodule

/* File: verification/test_hub_mode_and_alert_control.sv */
`timescale 1ns/1ps
module test_hub_mode_and_alert_control;
  localparam int unsigned HOLD = 20;
  localparam int unsigned INIT = 4;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [7:0]          event_cond;
  logic                usb_configured;
  logic                usb_suspended;
  hub_pkg::op_mode_e   op_mode;
  hub_pkg::hub_stage_e stage;
  logic                switch_on;
  logic                reg12_on;
  logic                reg33_on;
  logic                pll_run;
  logic                ports_en;
  logic                rom_load;
  logic [31:0]         rd;
  logic                err;
  int                  miscompares;
  int                  num_checks;
  int                  loads;
  wire [6:0]           pins = {op_mode, stage, switch_on, reg12_on, pll_run};

  hub_link_if link ();

  hub_ctrl_host #(.RESET_HOLD_CYCLES(HOLD)) i_hub_ctrl_host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));

  hub_ctrl_dev #(.INIT_CYCLES(INIT)) i_hub_ctrl_dev (
    .pclk(pclk), .presetn(presetn), .link(link), .event_cond(event_cond),
    .usb_configured(usb_configured), .usb_suspended(usb_suspended),
    .op_mode(op_mode), .stage(stage), .switch_on(switch_on),
    .reg12_on(reg12_on), .reg33_on(reg33_on), .pll_run(pll_run),
    .ports_en(ports_en), .rom_load(rom_load));

  hub_mode_and_alert_control_checker #(.HOLD_CYCLES(HOLD)) i_checker (
    .pclk(pclk), .presetn(presetn), .reset_n(link.reset_n),
    .bypass_n(link.bypass_n), .alert_oe(link.alert_oe),
    .alert_n(link.alert_n), .reg_req(link.reg_req), .reg_we(link.reg_we),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_ack(link.reg_ack));

  // Clock at 100 MHz
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Counts initialisation loads
  always @(posedge pclk)
    if (rom_load === 1'b1)
      loads++;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait ends at the first edge that sees ready high; the watchdog ends a hang
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Serial access through the controller, polled until idle
  task automatic ser(input logic we, input logic [7:0] a,
                     input logic [7:0] d);
    apb(1'b1, hub_pkg::SER_OFF, {15'h0000, we, a, d});
    do
    begin
      apb(1'b0, hub_pkg::STAT_OFF, 32'h0);
    end
    while (rd[hub_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic sreg(input logic [7:0] a, input logic [7:0] e);
    ser(1'b0, a, 8'h00);
    check("serial reg", {24'h0, rd[15:8]}, {24'h0, e});
  endtask

  task automatic alert(input logic e);
    repeat (4) @(posedge pclk);
    apb(1'b0, hub_pkg::STAT_OFF, 32'h0);
    check("alert flag", {31'h0, rd[1]}, {31'h0, e});
    check("alert pin", {31'h0, link.alert_n}, {31'h0, ~e});
  endtask

  task automatic wait_for(input logic st, input logic [1:0] v);
    while ((st ? 2'(stage) : 2'(op_mode)) !== v)
    begin
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask

  task automatic set_cond(input logic [7:0] v);
    @(posedge pclk);
    event_cond <= v;
    repeat (4) @(posedge pclk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    report_and_stop();
  end

  // Test sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    event_cond = 8'h00;
    usb_configured = 1'b0;
    usb_suspended = 1'b0;
    miscompares = 0;
    num_checks = 0;
    loads = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, hub_pkg::STAT_OFF, 32'h0);
    check("status", rd, 32'h0);
    check("status error", {31'h0, err}, 32'h0);
    check("pins", {25'h0, pins}, 32'h0);
    check("rails", {30'h0, reg33_on, ports_en}, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    $display("test reset ends");
    apb(1'b1, hub_pkg::CMD_OFF, 32'h2);
    wait_for(1'b1, hub_pkg::STAGE_CONFIG);
    check("pins", {25'h0, pins}, {25'h0, hub_pkg::MODE_HUB,
      hub_pkg::STAGE_CONFIG, 3'b011});
    check("loads", loads, 32'h1);
    sreg(hub_pkg::EVENT_FLAG_ADDR, hub_pkg::EVENT_FLAG_RESET);
    sreg(hub_pkg::EVENT_MASK_ADDR, hub_pkg::EVENT_MASK_RESET);
    $display("test hub ends");
    set_cond(8'h01);
    sreg(hub_pkg::EVENT_FLAG_ADDR, 8'h01);
    alert(1'b0);
    ser(1'b1, hub_pkg::EVENT_MASK_ADDR, 8'h01);
    alert(1'b1);
    ser(1'b1, hub_pkg::EVENT_FLAG_ADDR, 8'h01);
    sreg(hub_pkg::EVENT_FLAG_ADDR, 8'h00);
    alert(1'b0);
    set_cond(8'h00);
    set_cond(8'h01);
    set_cond(8'h00);
    sreg(hub_pkg::EVENT_FLAG_ADDR, 8'h01);
    alert(1'b1);
    $display("test events ends");
    ser(1'b1, hub_pkg::PORTABLE_CFG_ADDR, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      usb_configured <= i[0];
      usb_suspended  <= i[1];
      repeat (4) @(posedge pclk);
      check("level", {31'h0, link.alert_n}, {31'h0, i[0] & ~i[1]});
    end
    $display("test level ends");
    ser(1'b1, hub_pkg::PORTABLE_CFG_ADDR, 8'h03);
    wait_for(1'b1, hub_pkg::STAGE_COM);
    repeat (40) @(posedge pclk);
    check("pins", {25'h0, pins}, {25'h0, hub_pkg::MODE_HUB,
      hub_pkg::STAGE_COM, 3'b011});
    check("rails", {30'h0, reg33_on, ports_en}, 32'h3);
    apb(1'b1, hub_pkg::CMD_OFF, 32'h1);
    wait_for(1'b0, hub_pkg::MODE_BYPASS);
    check("pins", {25'h0, pins}, {25'h0, hub_pkg::MODE_BYPASS,
      hub_pkg::STAGE_OFF, 3'b100});
    check("rails", {30'h0, reg33_on, ports_en}, 32'h2);
    alert(1'b0);
    check("pin mode", {30'h0, rd[3:2]}, 32'h2);
    $display("test bypass ends");
    apb(1'b1, hub_pkg::CMD_OFF, 32'h2);
    wait_for(1'b1, hub_pkg::STAGE_CONFIG);
    // Bypass entry shows hub pins for a cycle, which starts one more init
    check("loads", loads, 32'h3);
    sreg(hub_pkg::PORTABLE_CFG_ADDR, 8'h00);
    sreg(hub_pkg::EVENT_MASK_ADDR, 8'h00);
    sreg(hub_pkg::EVENT_FLAG_ADDR, 8'h00);
    apb(1'b1, hub_pkg::CMD_OFF, 32'h0);
    wait_for(1'b0, hub_pkg::MODE_STANDBY);
    check("pins", {25'h0, pins}, 32'h0);
    check("rails", {30'h0, reg33_on, ports_en}, 32'h0);
    $display("test standby ends");
    report_and_stop();
  end
endmodule
